// ==== design/latched_driver_regs.vh ====
// Register offsets, fields, reset values and response codes of the driver
`ifndef LATCHED_DRIVER_REGS_VH
`define LATCHED_DRIVER_REGS_VH
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_IRQ_STAT    8'h08
`define OFS_IRQ_CLR     8'h0C
`define OFS_IRQ_EN      8'h10
`define OFS_SHIFT       8'h14
`define OFS_LATCH       8'h18
`define OFS_OUTPUT      8'h1C
`define OFS_SENSE       8'h20
`define CTRL_SERIAL_IN  0
`define CTRL_SHIFT_CLK  1
`define CTRL_CLEAR      2
`define CTRL_STROBE     3
`define CTRL_DISABLE    4
`define CTRL_UVLO       5
`define CTRL_OVERTEMP   6
`define CTRL_WIDTH      7
`define CTRL_RESET      7'h10
`define STAT_FAULT_N    0
`define STAT_SERIAL_OUT 1
`define STAT_OVERCUR    15:8
`define IRQ_OVERCUR     0
`define IRQ_OVERTEMP    1
`define IRQ_CLEARED     2
`define IRQ_WIDTH       3
`define IRQ_EN_RESET    3'h0
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define CH_COUNT        8
`endif

// ==== design/edge_sync.v ====
// Two-stage synchroniser with rising edge detection for one level
`timescale 1ns/1ns
`default_nettype none
module edge_sync (
	input  wire clk_sys_in,
	input  wire rst_in,
	input  wire async_in,
	output reg  level_out,
	output reg  rise_out
);
	reg meta;
	reg prev;
	// First stage feeds only the second stage
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			meta      <= 1'b0;
			level_out <= 1'b0;
			prev      <= 1'b0;
			rise_out  <= 1'b0;
		end else begin
			meta      <= async_in;
			level_out <= meta;
			prev      <= level_out;
			rise_out  <= level_out & ~prev;
		end
	end
endmodule // edge_sync
`default_nettype wire

// ==== design/latched_driver.v ====
// Serial-input latched eight-channel driver control with AXI4-Lite access
// Summary of operation
// - Shift clock rising edge captures serial input into stage one.
// - Each shift clock rising edge moves every stage toward serial output.
// - Clear held high makes shift edges load zeros instead of data.
// - Strobe high makes latches follow the shift register; low holds.
// - Output disable forces outputs off, keeps latch and shift contents.
// - Enabled and fault-free, each output follows its latch.
// - Output disable high clears latched overcurrent faults and the flag.
// - Overtemperature is not latched and recovers by itself.
// - Overcurrent turns its channel off and lowers the flag until reset.
// - Overtemperature turns all outputs off and lowers the flag meanwhile.
// - Undervoltage acts like output disable held high.
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "latched_driver_regs.vh"
module latched_driver (
	input  wire        clk_sys_in,
	input  wire        rst_in,
	input  wire        shift_clk_in,
	input  wire        serial_in,
	input  wire        clear_in,
	input  wire        strobe_in,
	input  wire        out_disable_in,
	input  wire        undervolt_in,
	input  wire        overtemp_in,
	input  wire [7:0]  overcur_in,
	output reg  [7:0]  drive_out,
	output reg         serial_out,
	output reg         fault_n_out,
	output reg         irq_out,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);
	// Software-visible state: control copy of the pins and event bits
	reg  [`CTRL_WIDTH-1:0] ctrl;
	reg  [`IRQ_WIDTH-1:0]  irq_stat;
	reg  [`IRQ_WIDTH-1:0]  irq_en;
	reg  [7:0]             shift_reg;
	reg  [7:0]             latch;
	reg  [7:0]             oc_fault;

	// Write channel halves are held until both have arrived
	reg  [7:0]             aw_addr;
	reg                    aw_held;
	reg  [31:0]            w_data;
	reg  [3:0]             w_strb;
	reg                    w_held;

	// Combinational next values
	reg  [31:0]            next_rdata;
	reg  [1:0]             next_rresp;
	reg  [`IRQ_WIDTH-1:0]  irq_clr;
	reg  [`IRQ_WIDTH-1:0]  irq_set;
	reg  [7:0]             oc_clean;

	// Synchronised levels; only the pins need their rising edges
	wire [7:0]             sense_level;
	wire [7:0]             pin_level;
	wire [7:0]             pin_rise;
	wire                   shift_edge;
	wire                   ser_lvl;
	wire                   clr_lvl;
	wire                   stb_lvl;
	wire                   dis_lvl;
	wire                   uv_lvl;
	wire                   ot_lvl;
	wire                   off_all;
	wire                   wr_go;

	// Control register bits that stand in for the pins
	wire                   sw_shift;
	wire                   sw_ser;
	wire                   sw_clr;
	wire                   sw_stb;
	wire                   sw_dis;
	wire                   sw_uv;
	wire                   sw_ot;

	// Every pin and every overcurrent line crosses through two flops
	// A pulse shorter than one system clock may slip between samples
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_oc
			edge_sync u_oc (
				.clk_sys_in (clk_sys_in),
				.rst_in     (rst_in),
				.async_in   (overcur_in[g]),
				.level_out  (sense_level[g]),
				// A trip is judged by level against the driven state
				.rise_out   ()
			);
		end
	endgenerate

	// Pin bundle: shift clock, data, clear, strobe, disable, undervolt, temp
	// Bit seven is a spare that keeps the bundle a byte wide
	wire [7:0] pin_raw = {1'b0, overtemp_in, undervolt_in, out_disable_in,
		strobe_in, clear_in, serial_in, shift_clk_in};
	generate
		for (g = 0; g < 7; g = g + 1) begin : g_pin
			edge_sync u_pin (
				.clk_sys_in (clk_sys_in),
				.rst_in     (rst_in),
				.async_in   (pin_raw[g]),
				.level_out  (pin_level[g]),
				.rise_out   (pin_rise[g])
			);
		end
	endgenerate
	assign pin_level[7] = 1'b0;
	assign pin_rise[7]  = 1'b0;

	// Software may also drive the pins through the control register
	// Each bit is ORed with its pin, so either side can raise it
	assign sw_shift = ctrl[`CTRL_SHIFT_CLK];
	assign sw_ser   = ctrl[`CTRL_SERIAL_IN];
	assign sw_clr   = ctrl[`CTRL_CLEAR];
	assign sw_stb   = ctrl[`CTRL_STROBE];
	assign sw_dis   = ctrl[`CTRL_DISABLE];
	assign sw_uv    = ctrl[`CTRL_UVLO];
	assign sw_ot    = ctrl[`CTRL_OVERTEMP];
	reg sw_shift_d;
	assign shift_edge = pin_rise[0] | (sw_shift & ~sw_shift_d);
	assign ser_lvl = pin_level[1] | sw_ser;
	assign clr_lvl = pin_level[2] | sw_clr;
	assign stb_lvl = pin_level[3] | sw_stb;
	assign dis_lvl = pin_level[4] | sw_dis;
	assign uv_lvl  = pin_level[5] | sw_uv;
	assign ot_lvl  = pin_level[6] | sw_ot;
	// Undervoltage behaves exactly as a held disable
	assign off_all = dis_lvl | uv_lvl;

	// Shift register; data moves toward stage eight on each shift edge
	// A pin edge acts one cycle later than a pin level, so data and clear must stand
	// at least that long around the edge
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			shift_reg  <= 8'h00;
			sw_shift_d <= 1'b0;
		end else begin
			sw_shift_d <= sw_shift;
			if (shift_edge) begin
				// Clear wins over data so a held clear empties the chain
				shift_reg <= {shift_reg[6:0], ser_lvl & ~clr_lvl};
			end
		end
	end

	// Latches are transparent while strobe is high; disable leaves them be
	// The strobe is sampled, so a pulse under one clock may not load
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			latch <= 8'h00;
		end else if (stb_lvl) begin
			latch <= shift_reg;
		end
	end

	// Overcurrent faults latch until disable or undervoltage resets them
	// Only a driven channel can trip; a line sensed while off is ignored
	always @* begin
		oc_clean = oc_fault;
		if (off_all) begin
			oc_clean = 8'h00;
		end
	end
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			oc_fault <= 8'h00;
		end else begin
			// A sensed trip on a driven channel survives a simultaneous reset
			oc_fault <= oc_clean | (sense_level & drive_out);
		end
	end

	// Output stage and the active-low flag; temperature is never stored
	// The flag reflects stored trips and live overtemperature only
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			drive_out   <= 8'h00;
			serial_out  <= 1'b0;
			fault_n_out <= 1'b1;
		end else begin
			serial_out <= shift_reg[7];
			if (off_all | ot_lvl) begin
				drive_out <= 8'h00;
			end else begin
				drive_out <= latch & ~oc_fault;
			end
			fault_n_out <= ~(ot_lvl | (|oc_fault));
		end
	end

	// Interrupt events: overcurrent trip, overtemperature pin rise, fault reset
	// A trip is a fault bit about to be set, so a load already shorted
	// when its channel turns on is still reported
	always @* begin
		irq_set = 3'h0;
		irq_set[`IRQ_OVERCUR]  = |(sense_level & drive_out & ~oc_fault);
		irq_set[`IRQ_OVERTEMP] = pin_rise[6];
		irq_set[`IRQ_CLEARED]  = (|oc_fault) & off_all;
	end

	// Register bus: write channels may arrive in either order
	// The clear strobe is live only in the cycle a write is applied
	assign wr_go = aw_held & w_held & ~s_axi_bvalid;
	always @* begin
		irq_clr = 3'h0;
		if (wr_go && aw_addr == `OFS_IRQ_CLR && w_strb[0]) begin
			irq_clr = w_data[`IRQ_WIDTH-1:0];
		end
	end
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			ctrl          <= `CTRL_RESET;
			irq_en        <= `IRQ_EN_RESET;
		end else begin
			// Each half is captured on its own handshake and held
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr       <= s_axi_awaddr;
				aw_held       <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				w_held       <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			// Both halves held: apply the write and raise the response
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bresp  <= `RESP_OKAY;
				if (aw_addr == `OFS_CTRL) begin
					if (w_strb[0]) begin
						ctrl <= w_data[`CTRL_WIDTH-1:0];
					end
				end else if (aw_addr == `OFS_IRQ_EN) begin
					if (w_strb[0]) begin
						irq_en <= w_data[`IRQ_WIDTH-1:0];
					end
				end else if (aw_addr != `OFS_IRQ_CLR) begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			end
			// Readies return once the response is taken: one write at a time
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Sticky event bits and the interrupt level they raise
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			irq_stat <= 3'h0;
			irq_out  <= 1'b0;
		end else begin
			// Set beats clear so an event in the clearing cycle stays
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
			// Registered so the pin never glitches; it trails status by one
			irq_out  <= |(irq_stat & irq_en);
		end
	end

	// Read decode
	// Unmapped offsets answer with an error and zero data
	always @* begin
		next_rdata = 32'h00000000;
		next_rresp = `RESP_OKAY;
		if (s_axi_araddr == `OFS_CTRL) begin
			next_rdata[`CTRL_WIDTH-1:0] = ctrl;
		end else if (s_axi_araddr == `OFS_STATUS) begin
			next_rdata[`STAT_FAULT_N]    = fault_n_out;
			next_rdata[`STAT_SERIAL_OUT] = serial_out;
			next_rdata[`STAT_OVERCUR]    = oc_fault;
		end else if (s_axi_araddr == `OFS_IRQ_STAT) begin
			next_rdata[`IRQ_WIDTH-1:0] = irq_stat;
		end else if (s_axi_araddr == `OFS_IRQ_CLR) begin
			next_rdata = 32'h00000000;
		end else if (s_axi_araddr == `OFS_IRQ_EN) begin
			next_rdata[`IRQ_WIDTH-1:0] = irq_en;
		end else if (s_axi_araddr == `OFS_SHIFT) begin
			next_rdata[7:0] = shift_reg;
		end else if (s_axi_araddr == `OFS_LATCH) begin
			next_rdata[7:0] = latch;
		end else if (s_axi_araddr == `OFS_OUTPUT) begin
			next_rdata[7:0] = drive_out;
		end else if (s_axi_araddr == `OFS_SENSE) begin
			next_rdata[7:0] = sense_level;
		end else begin
			next_rresp = `RESP_SLVERR;
		end
	end
	// Data are captured with the address, so one read sees one instant
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule // latched_driver
`default_nettype wire

// ==== testbench/latched_driver_props.sv ====
// Port-level assertions for the latched driver
`timescale 1ns/1ns
`default_nettype none
module latched_driver_props (
	input wire logic       clk_sys_in,
	input wire logic       rst_in,
	input wire logic       shift_clk_in,
	input wire logic       out_disable_in,
	input wire logic       undervolt_in,
	input wire logic       overtemp_in,
	input wire logic [7:0] overcur_in,
	input wire logic [7:0] drive_out,
	input wire logic       serial_out,
	input wire logic       fault_n_out,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready
);
	// Pins pass two flops and a register, so windows span five or six cycles
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	dis_off_a: assert property (
		out_disable_in[*5] |-> drive_out == 8'h00)
		else $error("drive on while disabled");
	uv_off_a: assert property (
		undervolt_in[*5] |-> drive_out == 8'h00)
		else $error("drive on in undervoltage");
	ot_off_a: assert property (
		overtemp_in[*5] |-> drive_out == 8'h00 && !fault_n_out)
		else $error("overtemperature not reported");
	flag_reset_a: assert property (
		(out_disable_in && !overtemp_in && overcur_in == 8'h00)[*6]
		|-> fault_n_out) else $error("flag not reset");
	sout_hold_a: assert property (
		(!shift_clk_in && !s_axi_wvalid)[*6] |-> $stable(serial_out))
		else $error("serial out moved without edge");
	wr_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	rd_resp_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	rd_once_a: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answered twice");
endmodule // latched_driver_props
`default_nettype wire

// ==== testbench/host_link.sv ====
// Behavioural host that drives the serial chain pins
`timescale 1ns/1ns
`default_nettype none
module host_link (
	output var logic shift_clk_out,
	output var logic serial_out,
	output var logic clear_out,
	output var logic strobe_out,
	output var logic disable_out
);
	initial {shift_clk_out, serial_out, clear_out, strobe_out,
		disable_out} = 5'h00;
	// Eight bits, first bit sent ends in stage eight; clock idles low
	task send(input [7:0] b, input clr);
		integer i;
		begin
			#37 clear_out = clr;
			if (strobe_out)
				disable_out = 1'b1;
			for (i = 7; i >= 0; i = i - 1) begin
				serial_out = b[i];
				#400 shift_clk_out = 1'b1;
				#400 shift_clk_out = 1'b0;
			end
			// Data moves after the hold so a stale level is never trusted
			#400 serial_out = ~serial_out;
			clear_out = 1'b0;
		end
	endtask
	// Strobe waits past the last clock edge before opening the latches
	task load;
		begin
			#337 strobe_out = 1'b1;
			#400 strobe_out = 1'b0;
		end
	endtask
	task set_dis(input v);
		disable_out <= v;
	endtask
endmodule // host_link
`default_nettype wire

// ==== testbench/tb_latched_driver.sv ====
// Self-checking bench for the latched driver
`timescale 1ns/1ns
`default_nettype none
`include "latched_driver_regs.vh"
module tb_latched_driver;
	logic clk_sys_in, rst_in, shift_clk_in, serial_in, clear_in;
	logic strobe_in, out_disable_in, undervolt_in, overtemp_in;
	logic [7:0] overcur_in, drive_out, s_axi_awaddr, s_axi_araddr;
	logic serial_out, fault_n_out, irq_out, s_axi_awvalid, s_axi_awready;
	logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	integer n_errors = 0, checked = 0;
	latched_driver uut (.clk_sys_in, .rst_in, .shift_clk_in, .serial_in,
		.clear_in, .strobe_in, .out_disable_in, .undervolt_in, .overtemp_in,
		.overcur_in, .drive_out, .serial_out, .fault_n_out, .irq_out,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	host_link host (.shift_clk_out(shift_clk_in), .serial_out(serial_in),
		.clear_out(clear_in), .strobe_out(strobe_in),
		.disable_out(out_disable_in));
	initial clk_sys_in = 1'b0;
	always #50 clk_sys_in = ~clk_sys_in;
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			checked = checked + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("wrong value %s: expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task settle;
		repeat (8) @(posedge clk_sys_in);
	endtask
	// Ready lines for responses stay high, so a task ends on the answer
	task axw(input [7:0] a, input [31:0] d, input [1:0] r);
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			do begin
				@(posedge clk_sys_in);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
			end while (!s_axi_bvalid);
			chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
		end
	endtask
	task axr(input [7:0] a, input [31:0] e, input [1:0] r);
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			do begin
				@(posedge clk_sys_in);
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
			end while (!s_axi_rvalid);
			chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
			if (r == `RESP_OKAY) chk("rdata", e, s_axi_rdata);
		end
	endtask
	task t_regs;
		begin
			axr(`OFS_CTRL, 32'h00000010, `RESP_OKAY);
			axr(`OFS_STATUS, 32'h00000001, `RESP_OKAY);
			axr(`OFS_IRQ_EN, 32'h00000000, `RESP_OKAY);
			axr(8'h40, 32'h00000000, `RESP_SLVERR);
			axw(8'h40, 32'h000000FF, `RESP_SLVERR);
			axw(`OFS_CTRL, 32'h00000000, `RESP_OKAY);
		end
	endtask
	task t_shift;
		begin
			host.send(8'hA5, 1'b0);
			settle;
			chk("drive", 32'h0, {24'h0, drive_out});
			chk("serial", 32'h1, {31'h0, serial_out});
			host.load;
			settle;
			chk("drive", 32'hA5, {24'h0, drive_out});
			host.send(8'h3C, 1'b0);
			settle;
			chk("drive", 32'hA5, {24'h0, drive_out});
			axr(`OFS_STATUS, 32'h00000001, `RESP_OKAY);
		end
	endtask
	task t_clear;
		begin
			host.send(8'hFF, 1'b1);
			host.load;
			settle;
			chk("drive", 32'h0, {24'h0, drive_out});
			chk("serial", 32'h0, {31'h0, serial_out});
			host.send(8'hA5, 1'b0);
			host.load;
		end
	endtask
	task t_disable;
		begin
			host.set_dis(1'b1);
			settle;
			chk("drive", 32'h0, {24'h0, drive_out});
			host.set_dis(1'b0);
			settle;
			chk("drive", 32'hA5, {24'h0, drive_out});
		end
	endtask
	// Trip channel zero, then reset it by undervoltage or disable
	task t_trip(input uv);
		begin
			axw(`OFS_IRQ_EN, 32'h00000007, `RESP_OKAY);
			overcur_in <= 8'h01;
			settle;
			overcur_in <= 8'h00;
			settle;
			chk("drive", 32'hA4, {24'h0, drive_out});
			chk("flag", 32'h0, {31'h0, fault_n_out});
			chk("irq", 32'h1, {31'h0, irq_out});
			axr(`OFS_STATUS, 32'h00000102, `RESP_OKAY);
			axw(`OFS_IRQ_EN, 32'h00000000, `RESP_OKAY);
			// The level trails the enable by one cycle
			@(posedge clk_sys_in);
			chk("irq", 32'h0, {31'h0, irq_out});
			if (uv) undervolt_in <= 1'b1;
			else host.set_dis(1'b1);
			settle;
			chk("drive", 32'h0, {24'h0, drive_out});
			undervolt_in <= 1'b0;
			host.set_dis(1'b0);
			settle;
			chk("drive", 32'hA5, {24'h0, drive_out});
			chk("flag", 32'h1, {31'h0, fault_n_out});
			axr(`OFS_IRQ_STAT, 32'h00000005, `RESP_OKAY);
			axw(`OFS_IRQ_CLR, 32'h00000007, `RESP_OKAY);
			axr(`OFS_IRQ_STAT, 32'h00000000, `RESP_OKAY);
		end
	endtask
	task t_otemp;
		begin
			axw(`OFS_IRQ_EN, 32'h00000002, `RESP_OKAY);
			overtemp_in <= 1'b1;
			settle;
			chk("drive", 32'h0, {24'h0, drive_out});
			chk("flag", 32'h0, {31'h0, fault_n_out});
			chk("irq", 32'h1, {31'h0, irq_out});
			overtemp_in <= 1'b0;
			settle;
			chk("drive", 32'hA5, {24'h0, drive_out});
			chk("flag", 32'h1, {31'h0, fault_n_out});
			axw(`OFS_IRQ_CLR, 32'h00000002, `RESP_OKAY);
			settle;
			chk("irq", 32'h0, {31'h0, irq_out});
		end
	endtask
	// Control bits stand in for the pins: shift, clear, strobe, disable
	task t_soft;
		begin
			axw(`OFS_CTRL, 32'h00000003, `RESP_OKAY);
			axw(`OFS_CTRL, 32'h00000000, `RESP_OKAY);
			axw(`OFS_CTRL, 32'h00000007, `RESP_OKAY);
			axw(`OFS_CTRL, 32'h00000000, `RESP_OKAY);
			axr(`OFS_SHIFT, 32'h00000096, `RESP_OKAY);
			axw(`OFS_CTRL, 32'h00000008, `RESP_OKAY);
			axw(`OFS_CTRL, 32'h00000010, `RESP_OKAY);
			settle;
			chk("drive", 32'h0, {24'h0, drive_out});
			axr(`OFS_LATCH, 32'h00000096, `RESP_OKAY);
			axw(`OFS_CTRL, 32'h00000000, `RESP_OKAY);
			settle;
			chk("drive", 32'h96, {24'h0, drive_out});
		end
	endtask
	task give_verdict;
		begin
			$display("comparisons %0d, errors %0d", checked, n_errors);
			if (n_errors == 0 && checked > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// Whole run needs about 550 cycles; the limit is far above that
	initial begin
		#3000000;
		n_errors = n_errors + 1;
		give_verdict;
	end
	initial begin
		{rst_in, s_axi_bready, s_axi_rready} = 3'h7;
		{undervolt_in, overtemp_in, s_axi_awvalid} = 3'h0;
		{s_axi_wvalid, s_axi_arvalid} = 2'h0;
		{overcur_in, s_axi_awaddr, s_axi_araddr} = 24'h000000;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		repeat (20) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(posedge clk_sys_in);
		t_regs;
		t_shift;
		t_clear;
		t_disable;
		t_trip(1'b0);
		t_trip(1'b1);
		t_otemp;
		t_soft;
		give_verdict;
	end
endmodule // tb_latched_driver
bind latched_driver latched_driver_props props (
	.clk_sys_in     (clk_sys_in),
	.rst_in         (rst_in),
	.shift_clk_in   (shift_clk_in),
	.out_disable_in (out_disable_in),
	.undervolt_in   (undervolt_in),
	.overtemp_in    (overtemp_in),
	.overcur_in     (overcur_in),
	.drive_out      (drive_out),
	.serial_out     (serial_out),
	.fault_n_out    (fault_n_out),
	.s_axi_awvalid  (s_axi_awvalid),
	.s_axi_awready  (s_axi_awready),
	.s_axi_wvalid   (s_axi_wvalid),
	.s_axi_wready   (s_axi_wready),
	.s_axi_bvalid   (s_axi_bvalid),
	.s_axi_arvalid  (s_axi_arvalid),
	.s_axi_arready  (s_axi_arready),
	.s_axi_rvalid   (s_axi_rvalid),
	.s_axi_rready   (s_axi_rready)
);
`default_nettype wire
